// file: design/tcpcs_pkg.sv
// Package: register map, field positions and reset values of the timer pair
package tcpcs_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] TCPCS_ADDR_CTRL  = 8'h88;
  localparam logic [7:0] TCPCS_ADDR_MODE  = 8'h89;
  localparam logic [7:0] TCPCS_ADDR_T0LO  = 8'h8A;
  localparam logic [7:0] TCPCS_ADDR_T1LO  = 8'h8B;
  localparam logic [7:0] TCPCS_ADDR_T0HI  = 8'h8C;
  localparam logic [7:0] TCPCS_ADDR_T1HI  = 8'h8D;
  localparam logic [7:0] TCPCS_ADDR_CLOCK_PRESCALE_CONTROL = 8'h8E;
  // ==========================================================
  // Reset values and clock control write mask
  localparam logic [7:0] TCPCS_RST_BYTE   = 8'h00;
  localparam logic [7:0] TCPCS_RST_CLOCK_PRESCALE_CONTROL  = 8'h01;
  localparam logic [7:0] TCPCS_CLOCK_PRESCALE_CONTROL_MASK = 8'h3F;
  // ==========================================================
  // Field positions
  localparam int TCPCS_CTRL_OVF1 = 7;
  localparam int TCPCS_CTRL_RUN1 = 6;
  localparam int TCPCS_CTRL_OVF0 = 5;
  localparam int TCPCS_CTRL_RUN0 = 4;
  localparam int TCPCS_MODE_GATE = 3;
  localparam int TCPCS_MODE_CT   = 2;
  localparam int TCPCS_CK_PS2    = 5;
  localparam int TCPCS_CK_PS1    = 4;
  localparam int TCPCS_CK_PS0    = 3;
  // ==========================================================
  // Prescale counts in system clocks
  localparam logic [3:0] TCPCS_DIV_SLOW = 4'hB;
  localparam logic [3:0] TCPCS_DIV_FAST = 4'h3;
  // ==========================================================
  // Operating modes
  typedef enum logic [1:0] {
    TCPCS_M13   = 2'b00,
    TCPCS_M16   = 2'b01,
    TCPCS_MRELD = 2'b10,
    TCPCS_MSPLT = 2'b11
  } tcpcs_mode_t;
endpackage

// file: design/tcpcs_timers.sv
// Two 16-bit timer/counters with gated counting and prescale select
// ==========================================================
`timescale 1ns/10ps
module tcpcs_timers
  import tcpcs_pkg::*;
(
  // Clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_reset,
  // Register port
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // External pins
  input  wire logic       i_ext_interrupt_pin_0,
  input  wire logic       i_ext_interrupt_pin_1,
  input  wire logic       i_count_input_pin_0,
  input  wire logic       i_count_input_pin_1,
  // Status
  output logic            o_timer0_overflow,
  output logic            o_timer1_overflow,
  output logic            o_prescale_select_2
);

  // ==========================================================
  // Registers
  logic [7:0] timer0_low_byte_r;
  logic [7:0] timer0_high_byte_r;
  logic [7:0] timer1_low_byte_r;
  logic [7:0] timer1_high_byte_r;
  logic [7:0] timer_mode_select_r;
  logic [7:0] clock_prescale_control_r;
  logic       run_control_0_r;
  logic       run_control_1_r;
  logic       ovf0_r;
  logic       ovf1_r;
  logic [3:0] pre0_r;
  logic [3:0] pre1_r;
  logic       cpin0_r;
  logic       cpin1_r;

  function automatic logic wr_hit(input logic [7:0] a);
    wr_hit = i_wr && (i_addr == a);
  endfunction

  // ==========================================================
  // Prescalers: per-timer divide by 12 or 4, core clock untouched
  logic tick0;
  logic tick1;
  assign tick0 = (pre0_r == (clock_prescale_control_r[TCPCS_CK_PS0] ?
                  TCPCS_DIV_FAST : TCPCS_DIV_SLOW));
  assign tick1 = (pre1_r == (clock_prescale_control_r[TCPCS_CK_PS1] ?
                  TCPCS_DIV_FAST : TCPCS_DIV_SLOW));

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      pre0_r <= 4'h0;
      pre1_r <= 4'h0;
    end else begin
      pre0_r <= tick0 ? 4'h0 : pre0_r + 4'h1;
      pre1_r <= tick1 ? 4'h0 : pre1_r + 4'h1;
    end
  end

  // Count pin falling edge detect
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      cpin0_r <= 1'b0;
      cpin1_r <= 1'b0;
    end else begin
      cpin0_r <= i_count_input_pin_0;
      cpin1_r <= i_count_input_pin_1;
    end
  end

  // ==========================================================
  // Count enables
  tcpcs_mode_t mode0;
  tcpcs_mode_t mode1;
  logic        src0;
  logic        src1;
  logic        inc0;
  logic        inc1;
  logic        inc0_hi;
  assign mode0 = tcpcs_mode_t'(timer_mode_select_r[1:0]);
  assign mode1 = tcpcs_mode_t'(timer_mode_select_r[5:4]);
  assign src0  = timer_mode_select_r[TCPCS_MODE_CT] ?
                 (cpin0_r && !i_count_input_pin_0) : tick0;
  assign src1  = timer_mode_select_r[TCPCS_MODE_CT + 4] ?
                 (cpin1_r && !i_count_input_pin_1) : tick1;
  assign inc0  = src0 && run_control_0_r &&
                 (!timer_mode_select_r[TCPCS_MODE_GATE] ||
                  i_ext_interrupt_pin_0);
  assign inc1  = src1 && run_control_1_r && (mode1 != TCPCS_MSPLT) &&
                 (!timer_mode_select_r[TCPCS_MODE_GATE + 4] ||
                  i_ext_interrupt_pin_1);
  // Split mode: high byte runs on prescaled clock under timer 1 run bit
  assign inc0_hi = tick0 && run_control_1_r;

  // ==========================================================
  // Timer 0 counting
  logic [7:0] t0lo_nxt;
  logic [7:0] t0hi_nxt;
  logic       t0_ovf;
  logic       t0_ovf_hi;
  always_comb begin
    t0lo_nxt  = timer0_low_byte_r;
    t0hi_nxt  = timer0_high_byte_r;
    t0_ovf    = 1'b0;
    t0_ovf_hi = 1'b0;
    unique case (mode0)
      TCPCS_M13: begin
        if (inc0) begin
          t0lo_nxt = {3'h0, timer0_low_byte_r[4:0] + 5'h01};
          if (timer0_low_byte_r[4:0] == 5'h1F) begin
            t0hi_nxt = timer0_high_byte_r + 8'h01;
            t0_ovf   = (timer0_high_byte_r == 8'hFF);
          end
        end
      end
      TCPCS_M16: begin
        if (inc0) begin
          {t0hi_nxt, t0lo_nxt} = {timer0_high_byte_r, timer0_low_byte_r} + 16'h0001;
          t0_ovf = ({timer0_high_byte_r, timer0_low_byte_r} == 16'hFFFF);
        end
      end
      TCPCS_MRELD: begin
        if (inc0) begin
          t0_ovf   = (timer0_low_byte_r == 8'hFF);
          t0lo_nxt = t0_ovf ? timer0_high_byte_r : timer0_low_byte_r + 8'h01;
        end
      end
      TCPCS_MSPLT: begin
        if (inc0) begin
          t0lo_nxt = timer0_low_byte_r + 8'h01;
          t0_ovf   = (timer0_low_byte_r == 8'hFF);
        end
        if (inc0_hi) begin
          t0hi_nxt  = timer0_high_byte_r + 8'h01;
          t0_ovf_hi = (timer0_high_byte_r == 8'hFF);
        end
      end
    endcase
  end

  // ==========================================================
  // Timer 1 counting
  logic [7:0] t1lo_nxt;
  logic [7:0] t1hi_nxt;
  logic       t1_ovf;
  always_comb begin
    t1lo_nxt = timer1_low_byte_r;
    t1hi_nxt = timer1_high_byte_r;
    t1_ovf   = 1'b0;
    if (inc1) begin
      unique case (mode1)
        TCPCS_M13: begin
          t1lo_nxt = {3'h0, timer1_low_byte_r[4:0] + 5'h01};
          if (timer1_low_byte_r[4:0] == 5'h1F) begin
            t1hi_nxt = timer1_high_byte_r + 8'h01;
            t1_ovf   = (timer1_high_byte_r == 8'hFF);
          end
        end
        TCPCS_M16: begin
          {t1hi_nxt, t1lo_nxt} = {timer1_high_byte_r, timer1_low_byte_r} + 16'h0001;
          t1_ovf = ({timer1_high_byte_r, timer1_low_byte_r} == 16'hFFFF);
        end
        TCPCS_MRELD: begin
          t1_ovf   = (timer1_low_byte_r == 8'hFF);
          t1lo_nxt = t1_ovf ? timer1_high_byte_r : timer1_low_byte_r + 8'h01;
        end
        TCPCS_MSPLT: begin
          t1_ovf = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Count registers, software write has priority over counting
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      timer0_low_byte_r  <= TCPCS_RST_BYTE;
      timer0_high_byte_r <= TCPCS_RST_BYTE;
      timer1_low_byte_r  <= TCPCS_RST_BYTE;
      timer1_high_byte_r <= TCPCS_RST_BYTE;
    end else begin
      timer0_low_byte_r  <= wr_hit(TCPCS_ADDR_T0LO) ? i_wdata : t0lo_nxt;
      timer0_high_byte_r <= wr_hit(TCPCS_ADDR_T0HI) ? i_wdata : t0hi_nxt;
      timer1_low_byte_r  <= wr_hit(TCPCS_ADDR_T1LO) ? i_wdata : t1lo_nxt;
      timer1_high_byte_r <= wr_hit(TCPCS_ADDR_T1HI) ? i_wdata : t1hi_nxt;
    end
  end

  // ==========================================================
  // Control, mode and clock control registers
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      timer_mode_select_r      <= TCPCS_RST_BYTE;
      clock_prescale_control_r <= TCPCS_RST_CLOCK_PRESCALE_CONTROL;
      run_control_0_r          <= 1'b0;
      run_control_1_r          <= 1'b0;
    end else begin
      if (wr_hit(TCPCS_ADDR_MODE)) begin
        timer_mode_select_r <= i_wdata;
      end
      if (wr_hit(TCPCS_ADDR_CLOCK_PRESCALE_CONTROL)) begin
        clock_prescale_control_r <= i_wdata & TCPCS_CLOCK_PRESCALE_CONTROL_MASK;
      end
      if (wr_hit(TCPCS_ADDR_CTRL)) begin
        run_control_0_r <= i_wdata[TCPCS_CTRL_RUN0];
        run_control_1_r <= i_wdata[TCPCS_CTRL_RUN1];
      end
    end
  end

  // Overflow flags: hardware set wins over software write
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      ovf0_r <= 1'b0;
      ovf1_r <= 1'b0;
    end else begin
      if (t0_ovf) begin
        ovf0_r <= 1'b1;
      end else if (wr_hit(TCPCS_ADDR_CTRL)) begin
        ovf0_r <= i_wdata[TCPCS_CTRL_OVF0];
      end
      if (t1_ovf || t0_ovf_hi) begin
        ovf1_r <= 1'b1;
      end else if (wr_hit(TCPCS_ADDR_CTRL)) begin
        ovf1_r <= i_wdata[TCPCS_CTRL_OVF1];
      end
    end
  end

  // ==========================================================
  // Read data, one cycle after the read strobe
  logic [7:0] rd_mux;
  always_comb begin
    unique case (i_addr)
      TCPCS_ADDR_CTRL:  rd_mux = {ovf1_r, run_control_1_r, ovf0_r, run_control_0_r, 4'h0};
      TCPCS_ADDR_MODE:  rd_mux = timer_mode_select_r;
      TCPCS_ADDR_T0LO:  rd_mux = timer0_low_byte_r;
      TCPCS_ADDR_T1LO:  rd_mux = timer1_low_byte_r;
      TCPCS_ADDR_T0HI:  rd_mux = timer0_high_byte_r;
      TCPCS_ADDR_T1HI:  rd_mux = timer1_high_byte_r;
      TCPCS_ADDR_CLOCK_PRESCALE_CONTROL: rd_mux = clock_prescale_control_r;
      default:          rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_rd ? rd_mux : 8'h00;
    end
  end

  assign o_timer0_overflow   = ovf0_r;
  assign o_timer1_overflow   = ovf1_r;
  assign o_prescale_select_2 = clock_prescale_control_r[TCPCS_CK_PS2];

  // ==========================================================
  // Checks
  property p_gate0;
    @(posedge i_core_clk) disable iff (i_reset)
      (timer_mode_select_r[TCPCS_MODE_GATE] && !i_ext_interrupt_pin_0) |-> !inc0;
  endproperty
  a_gate0: assert property (p_gate0) else $error("timer 0 counted with gate low");

  property p_halt0;
    @(posedge i_core_clk) disable iff (i_reset)
      (!run_control_0_r && !i_wr) |=> $stable(timer0_low_byte_r);
  endproperty
  a_halt0: assert property (p_halt0) else $error("halted timer 0 changed");

  property p_m3hold1;
    @(posedge i_core_clk) disable iff (i_reset)
      (mode1 == TCPCS_MSPLT && !i_wr) |=> $stable({timer1_high_byte_r, timer1_low_byte_r});
  endproperty
  a_m3hold1: assert property (p_m3hold1) else $error("timer 1 moved in mode 3");

  property p_reload0;
    @(posedge i_core_clk) disable iff (i_reset)
      (mode0 == TCPCS_MRELD && inc0 && timer0_low_byte_r == 8'hFF && !i_wr)
      |=> (timer0_low_byte_r == $past(timer0_high_byte_r)) && ovf0_r;
  endproperty
  a_reload0: assert property (p_reload0) else $error("reload failed");

  property p_wrap16;
    @(posedge i_core_clk) disable iff (i_reset)
      (mode0 == TCPCS_M16 && inc0 && {timer0_high_byte_r, timer0_low_byte_r} == 16'hFFFF
       && !i_wr) |=> ({timer0_high_byte_r, timer0_low_byte_r} == 16'h0000) && ovf0_r;
  endproperty
  a_wrap16: assert property (p_wrap16) else $error("16-bit wrap failed");

  // Select held: no write in the four cycles the period spans
  property p_div4;
    @(posedge i_core_clk) disable iff (i_reset)
      (tick0 && clock_prescale_control_r[TCPCS_CK_PS0] && !i_wr) ##1 !i_wr [*3]
      |-> (!$past(tick0, 2) && !$past(tick0) && !tick0) ##1 tick0;
  endproperty
  a_div4: assert property (p_div4) else $error("divide by 4 wrong");

  property p_ck_top;
    @(posedge i_core_clk) disable iff (i_reset)
      clock_prescale_control_r[7:6] == 2'b00;
  endproperty
  a_ck_top: assert property (p_ck_top) else $error("clock control top bits set");

  property p_m13;
    @(posedge i_core_clk) disable iff (i_reset)
      (mode0 == TCPCS_M13 && inc0 && timer0_low_byte_r[4:0] != 5'h1F && !i_wr)
      |=> $stable(timer0_high_byte_r);
  endproperty
  a_m13: assert property (p_m13) else $error("13-bit carry early");

endmodule

// file: tb/tcpcs_pin_model.sv
// Pin-level model of the gate and external count inputs
`timescale 1ns/10ps
module tcpcs_pin_model (
  // Clock
  input  wire logic i_core_clk,
  // Pins
  output logic      o_ext_interrupt_pin_0,
  output logic      o_ext_interrupt_pin_1,
  output logic      o_count_input_pin_0,
  output logic      o_count_input_pin_1
);
  logic [1:0] gate_r = 2'b00;
  logic [1:0] cnt_r  = 2'b11;

  assign o_ext_interrupt_pin_0 = gate_r[0];
  assign o_ext_interrupt_pin_1 = gate_r[1];
  assign o_count_input_pin_0   = cnt_r[0];
  assign o_count_input_pin_1   = cnt_r[1];

  // ==========================================================
  // Gate level, changed just after an edge
  task automatic set_gate(input int idx, input logic v);
    @(posedge i_core_clk);
    gate_r[idx] <= v;
  endtask

  // ==========================================================
  // One low pulse; its falling edge is the counted event
  task automatic pulse(input int idx);
    @(posedge i_core_clk);
    cnt_r[idx] <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    cnt_r[idx] <= 1'b1;
    repeat (3) @(posedge i_core_clk);
  endtask
endmodule

// file: tb/tb.sv
// Register-level testbench of the timer pair
`timescale 1ns/10ps
module tb;
  import tcpcs_pkg::*;
  logic       i_core_clk = 1'b0;
  logic       i_reset    = 1'b1;
  logic [7:0] i_addr     = 8'h00;
  logic [7:0] i_wdata    = 8'h00;
  logic       i_wr       = 1'b0;
  logic       i_rd       = 1'b0;
  logic [7:0] o_rdata;
  logic       ext_interrupt_pin_0, ext_interrupt_pin_1, cnt0, cnt1;
  logic       ovf0, ovf1, ps2;
  int         mismatches = 0;
  int         cmp_count  = 0;
  int         cycles     = 0;
  logic [7:0] v;

  always #10 i_core_clk = ~i_core_clk;

  tcpcs_timers dut (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_ext_interrupt_pin_0(ext_interrupt_pin_0), .i_ext_interrupt_pin_1(ext_interrupt_pin_1),
    .i_count_input_pin_0(cnt0), .i_count_input_pin_1(cnt1),
    .o_timer0_overflow(ovf0), .o_timer1_overflow(ovf1), .o_prescale_select_2(ps2));

  tcpcs_pin_model pins (
    .i_core_clk(i_core_clk), .o_ext_interrupt_pin_0(ext_interrupt_pin_0), .o_ext_interrupt_pin_1(ext_interrupt_pin_1),
    .o_count_input_pin_0(cnt0), .o_count_input_pin_1(cnt1));

  // ==========================================================
  // Verdict and hang guard
  task automatic summarize();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end

  // ==========================================================
  // Bus access and comparison
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd   <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  task automatic rng(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    logic [7:0] d;
    rd(a, d);
    chk({7'h00, (d >= lo) && (d <= hi)}, 8'h01);
  endtask

  // Run one timer from zero for 120 clocks on internal ticks
  task automatic rate(input bit t, input logic [7:0] ck, input logic [7:0] lo,
                      input logic [7:0] hi);
    wr(TCPCS_ADDR_CLOCK_PRESCALE_CONTROL, ck);
    wr(t ? TCPCS_ADDR_T1LO : TCPCS_ADDR_T0LO, 8'h00);
    wr(TCPCS_ADDR_MODE, t ? 8'h10 : 8'h01);
    wr(TCPCS_ADDR_CTRL, t ? 8'h40 : 8'h10);
    repeat (120) @(posedge i_core_clk);
    wr(TCPCS_ADDR_CTRL, 8'h00);
    rng(t ? TCPCS_ADDR_T1LO : TCPCS_ADDR_T0LO, lo, hi);
  endtask

  // Gate pin blocks, then allows, 40 fast clocks of counting
  task automatic gated(input int t);
    logic [7:0] a;
    a = t ? TCPCS_ADDR_T1LO : TCPCS_ADDR_T0LO;
    wr(TCPCS_ADDR_MODE, t ? 8'h90 : 8'h09);
    wr(a, 8'h00);
    wr(TCPCS_ADDR_CTRL, t ? 8'h40 : 8'h10);
    repeat (100) @(posedge i_core_clk);
    rdc(a, 8'h00);
    pins.set_gate(t, 1'b1);
    repeat (40) @(posedge i_core_clk);
    wr(TCPCS_ADDR_CTRL, 8'h00);
    rng(a, 8'h08, 8'h0B);
    pins.set_gate(t, 1'b0);
  endtask

  // Load both timer 0 bytes and deliver one count pulse
  task automatic load_pulse(input logic [7:0] md, input logic [7:0] lo, input logic [7:0] hi);
    wr(TCPCS_ADDR_CTRL, 8'h00);
    wr(TCPCS_ADDR_MODE, md);
    wr(TCPCS_ADDR_T0LO, lo);
    wr(TCPCS_ADDR_T0HI, hi);
    wr(TCPCS_ADDR_CTRL, 8'h10);
    pins.pulse(0);
  endtask

  // Load both timer 1 bytes and deliver one count pulse
  task automatic load_pulse1(input logic [7:0] md, input logic [7:0] lo, input logic [7:0] hi);
    wr(TCPCS_ADDR_CTRL, 8'h00);
    wr(TCPCS_ADDR_MODE, md);
    wr(TCPCS_ADDR_T1LO, lo);
    wr(TCPCS_ADDR_T1HI, hi);
    wr(TCPCS_ADDR_CTRL, 8'h40);
    pins.pulse(1);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge i_core_clk);
    i_reset <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rdc(TCPCS_ADDR_T0LO + 8'(i), 8'h00);
      wr(TCPCS_ADDR_T0LO + 8'(i), 8'hA5 ^ 8'(i * 8'h33));
    end
    for (int i = 0; i < 4; i++) begin
      rdc(TCPCS_ADDR_T0LO + 8'(i), 8'hA5 ^ 8'(i * 8'h33));
    end
    rdc(TCPCS_ADDR_CLOCK_PRESCALE_CONTROL, 8'h01);
    rdc(8'h80, 8'h00);
    wr(TCPCS_ADDR_CLOCK_PRESCALE_CONTROL, 8'hFF);
    rdc(TCPCS_ADDR_CLOCK_PRESCALE_CONTROL, 8'h3F);
    chk({7'h00, ps2}, 8'h01);
    // Slow ticks every 12 clocks, fast every 4
    rate(0, 8'h01, 8'h09, 8'h0B);
    rate(0, 8'h09, 8'h1D, 8'h1F);
    rate(1, 8'h11, 8'h1D, 8'h1F);
    rate(1, 8'h01, 8'h09, 8'h0B);
    chk({7'h00, ps2}, 8'h00);
    rd(TCPCS_ADDR_T1LO, v);
    repeat (50) @(posedge i_core_clk);
    rdc(TCPCS_ADDR_T1LO, v);
    wr(TCPCS_ADDR_CLOCK_PRESCALE_CONTROL, 8'h19);
    gated(0);
    gated(1);
    // External pulses counted one each
    load_pulse(8'h05, 8'h00, 8'h00);
    repeat (4) pins.pulse(0);
    rdc(TCPCS_ADDR_T0LO, 8'h05);
    load_pulse(8'h05, 8'hFF, 8'hFF);
    rdc(TCPCS_ADDR_T0LO, 8'h00);
    rdc(TCPCS_ADDR_T0HI, 8'h00);
    rdc(TCPCS_ADDR_CTRL, 8'h30);
    chk({7'h00, ovf0}, 8'h01);
    load_pulse(8'h06, 8'hFF, 8'hF0);
    rdc(TCPCS_ADDR_T0LO, 8'hF0);
    rdc(TCPCS_ADDR_T0HI, 8'hF0);
    chk({7'h00, ovf0}, 8'h01);
    load_pulse(8'h04, 8'h1F, 8'h05);
    rdc(TCPCS_ADDR_T0HI, 8'h06);
    rdc(TCPCS_ADDR_T0LO, 8'h00);
    chk({7'h00, ovf0}, 8'h00);
    load_pulse(8'h04, 8'h03, 8'h05);
    rdc(TCPCS_ADDR_T0LO, 8'h04);
    rdc(TCPCS_ADDR_T0HI, 8'h05);
    load_pulse(8'h04, 8'h1F, 8'hFF);
    chk({7'h00, ovf0}, 8'h01);
    load_pulse(8'h07, 8'hFF, 8'hFF);
    rdc(TCPCS_ADDR_T0LO, 8'h00);
    rdc(TCPCS_ADDR_T0HI, 8'hFF);
    chk({7'h00, ovf1}, 8'h00);
    wr(TCPCS_ADDR_CTRL, 8'h50);
    repeat (30) @(posedge i_core_clk);
    rdc(TCPCS_ADDR_CTRL, 8'hD0);
    wr(TCPCS_ADDR_CTRL, 8'h00);
    wr(TCPCS_ADDR_MODE, 8'h30);
    wr(TCPCS_ADDR_T1LO, 8'h77);
    wr(TCPCS_ADDR_CTRL, 8'h40);
    repeat (60) @(posedge i_core_clk);
    rdc(TCPCS_ADDR_T1LO, 8'h77);
    // Timer 1 on its count pin: reload, then 13-bit carry
    load_pulse1(8'h60, 8'hFF, 8'hA0);
    rdc(TCPCS_ADDR_T1LO, 8'hA0);
    chk({7'h00, ovf1}, 8'h01);
    load_pulse1(8'h40, 8'h1F, 8'h10);
    rdc(TCPCS_ADDR_T1HI, 8'h11);
    rdc(TCPCS_ADDR_T1LO, 8'h00);
    summarize();
  end
endmodule
